// file: rtl/pmsc_cfg.svh
`ifndef PMSC_CFG_SVH
`define PMSC_CFG_SVH

// clock and time figures
`define PM_CLK_HZ 100000000
`define PM_CLK_MHZ 100
`define PM_HOLD_US 1000
`define PM_SETTLE_US 200

// sample rates in samples per second
`define PM_SPS_1024 1024
`define PM_SPS_256 256
`define PM_SPS_64 64
`define PM_SPS_8 8

// register byte addresses (control keeps its printed index 1)
`define PM_IDX_CTRL 12'h001
`define PM_A_CMD 12'h000
`define PM_A_CTRL (`PM_IDX_CTRL * 12'h004)
`define PM_A_CFG 12'h008
`define PM_A_STAT 12'h00c
`define PM_A_COUNT 12'h010
`define PM_A_RES 12'h040
`define PM_RES_STRIDE 12'h010
`define PM_R_VOLT 4'h0
`define PM_R_POW 4'h4
`define PM_R_ACC 4'h8

// command codes
`define PM_CMD_CLEAR 8'h01
`define PM_CMD_KEEP 8'h02
`define PM_CMD_GLOBAL 8'h03

// rate codes
`define PM_RATE_1024 2'h0
`define PM_RATE_256 2'h1
`define PM_RATE_64 2'h2
`define PM_RATE_8 2'h3

// pin modes
`define PM_P1_RATE 2'h0
`define PM_P1_NOTIFY 2'h1
`define PM_P1_GPIN 2'h2
`define PM_P1_GPOUT 2'h3
`define PM_P2_GPIN 2'h0
`define PM_P2_GPOUT 2'h1
`define PM_P2_NOTIFY 2'h2

// reset values
`define PM_CTRL_RST 13'h003c
`define PM_CFG_RST 16'h0000

`endif

// file: rtl/pmsc_pkg.sv
package pmsc_pkg;

	typedef struct packed {
		logic fast;
		logic [1:0] pin2_mode;
		logic [1:0] pin1_mode;
		logic [1:0] gpio_out;
		logic [3:0] chan_en;
		logic [1:0] rate;
	} pmsc_ctrl_type;

	typedef struct packed {
		logic [7:0] sense_off;
		logic [7:0] bus_off;
	} pmsc_cfg_type;

	typedef struct packed {
		logic [31:0] acc;
		logic [29:0] power;
		logic [15:0] sense;
		logic [15:0] bus;
	} pmsc_res_type;

	typedef enum logic [2:0] {
		SEQ_BOUND,
		SEQ_START,
		SEQ_WAIT,
		SEQ_MATH,
		SEQ_SLEEP
	} pmsc_seq_type;

endpackage

// file: rtl/pmsc_ctrl.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "pmsc_cfg.svh"

// Summary of operation
// - rate pin in rate role and high forces 8 SPS on all channels
// - rate pin low gives 1024 SPS unless another rate is programmed
// - rate pin can become notify output one, gpio input or open-drain out
// - second pin resets as gpio input, may be open-drain out or notify two
// - power-down input low puts the whole device in power-down
// - after reset go active, sample enabled channels in turn, accumulate
// - default rate 1024 SPS, host may program 256, 64 or 8 SPS
// - below the top rate, sleep for the unused part of each cycle
// - capture bus and sense together, correct offset, multiply to power
// - clearing snapshot copies all results and holds them until next one
// - clearing snapshot zeroes accumulators and count, sampling goes on
// - keeping snapshot copies results, leaves accumulators and count
// - control writes wait for a snapshot, apply at the cycle boundary
// - results valid within 1 ms of a snapshot, readable until the next
// - fast mode with channels off: settle 200 us per channel plus one
// - commands written within 1 ms after a snapshot are refused, in fast mode with channels off within the settle time
// - pending control and configuration writes apply within one sample period of a snapshot, under 1 ms only at 1024 SPS
// - latched results come from the latest completed cycle only
// - the global snapshot command acts like the clearing snapshot
module pmsc_ctrl import pmsc_pkg::*; #(
	parameter int NCH = 4,
	parameter int PER_1024 = `PM_CLK_HZ / `PM_SPS_1024,
	parameter int PER_256 = `PM_CLK_HZ / `PM_SPS_256,
	parameter int PER_64 = `PM_CLK_HZ / `PM_SPS_64,
	parameter int PER_8 = `PM_CLK_HZ / `PM_SPS_8,
	parameter int HOLD_CYC = `PM_HOLD_US * `PM_CLK_MHZ,
	parameter int SETTLE_CYC = `PM_SETTLE_US * `PM_CLK_MHZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_down_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic adc_start,
	output logic [1:0] adc_chan,
	input wire logic adc_done,
	input wire logic [15:0] adc_bus,
	input wire logic [15:0] adc_sense,
	output logic sleep,
	output logic powered_down,
	input wire logic rate_force_or_notify1_pin_i,
	output logic rate_force_or_notify1_pin_o,
	output logic rate_force_or_notify1_pin_oe,
	input wire logic general_io_or_notify2_pin_i,
	output logic general_io_or_notify2_pin_o,
	output logic general_io_or_notify2_pin_oe
);

	if (NCH < 1 || NCH > 4)
		$error("pmsc_ctrl: NCH must be 1 to 4");
	if (PER_1024 < 8 * NCH || PER_8 < PER_64 || PER_64 < PER_256)
		$error("pmsc_ctrl: sample periods inconsistent");
	if (HOLD_CYC < 2 || SETTLE_CYC < 1)
		$error("pmsc_ctrl: hold times too short");

	// power-down acts like reset on all state except powered_down and the pin data outputs
	logic core_rst_n;
	assign core_rst_n = presetn & power_down_n;

	pmsc_ctrl_type pend_ctrl;
	pmsc_ctrl_type act_ctrl;
	pmsc_cfg_type pend_cfg;
	pmsc_cfg_type act_cfg;
	logic apply_pend;
	logic [31:0] hold_cnt;
	logic notify_flag;

	pmsc_seq_type seq;
	logic [1:0] ch;
	logic [31:0] pcnt;
	logic slow_cycle;
	logic [15:0] cur_bus;
	logic [15:0] cur_sense;
	logic cycle_done;

	pmsc_res_type live [NCH];
	pmsc_res_type comp [NCH];
	pmsc_res_type rd [NCH];
	logic [31:0] live_count;
	logic [31:0] comp_count;
	logic [31:0] rd_count;

	logic access;
	logic wr;
	logic cmd_wr;
	logic hold_busy;
	logic refuse;
	logic snap;
	logic snap_clear;
	logic [2:0] n_en;
	logic [31:0] win_len;
	logic [29:0] pow;
	logic [31:0] rate_per;
	logic last_ch;
	logic clear_pend;
	logic zero_now;

	assign access = psel & penable & ~pready;
	assign wr = access & pwrite;
	assign hold_busy = hold_cnt != 32'h0;
	assign cmd_wr = wr && paddr == `PM_A_CMD;
	// writes to command, control and config are refused in the hold window
	assign refuse = hold_busy && (paddr == `PM_A_CMD ||
		paddr == `PM_A_CTRL || paddr == `PM_A_CFG);
	assign snap_clear = cmd_wr && !hold_busy &&
		(pwdata[7:0] == `PM_CMD_CLEAR ||
		pwdata[7:0] == `PM_CMD_GLOBAL);
	assign snap = snap_clear ||
		(cmd_wr && !hold_busy && pwdata[7:0] == `PM_CMD_KEEP);
	assign pow = 30'(cur_bus[15:2]) * 30'(cur_sense);
	assign zero_now = cycle_done && (clear_pend || snap_clear);
	assign last_ch = 32'(ch) == NCH - 1;

	always_comb begin
		n_en = 3'h0;
		for (int i = 0; i < NCH; i++)
			n_en = n_en + 3'(act_ctrl.chan_en[i]);
	end

	// settle window length after a snapshot
	always_comb begin
		if (act_ctrl.fast && 32'(n_en) < NCH)
			win_len = 32'((n_en + 3'h1) * SETTLE_CYC);
		else
			win_len = 32'(HOLD_CYC);
	end

	// rate of the cycle about to start
	always_comb begin
		if (act_ctrl.pin1_mode == `PM_P1_RATE && rate_force_or_notify1_pin_i)
			rate_per = 32'(PER_8);
		else begin
			case (act_ctrl.rate)
			`PM_RATE_1024: rate_per = 32'(PER_1024);
			`PM_RATE_256: rate_per = 32'(PER_256);
			`PM_RATE_64: rate_per = 32'(PER_64);
			default: rate_per = 32'(PER_8);
			endcase
		end
	end

	// pending control and configuration
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pend_ctrl <= pmsc_ctrl_type'(`PM_CTRL_RST);
			pend_cfg <= pmsc_cfg_type'(`PM_CFG_RST);
		end else if (wr && !refuse) begin
			if (paddr == `PM_A_CTRL)
				pend_ctrl <= pmsc_ctrl_type'(pwdata[12:0]);
			if (paddr == `PM_A_CFG)
				pend_cfg <= pmsc_cfg_type'(pwdata[15:0]);
		end
	end

	// a snapshot arms the transfer of pending settings; set wins over clear
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n)
			apply_pend <= 1'b0;
		else if (snap)
			apply_pend <= 1'b1;
		else if (seq == SEQ_BOUND)
			apply_pend <= 1'b0;
	end

	// hold window after an accepted snapshot
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n)
			hold_cnt <= 32'h0;
		else if (snap)
			hold_cnt <= win_len;
		else if (hold_busy)
			hold_cnt <= hold_cnt - 32'h1;
	end

	// active settings change only between round-robin cycles
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			act_ctrl <= pmsc_ctrl_type'(`PM_CTRL_RST);
			act_cfg <= pmsc_cfg_type'(`PM_CFG_RST);
		end else if (seq == SEQ_BOUND && apply_pend) begin
			act_ctrl <= pend_ctrl;
			act_cfg <= pend_cfg;
		end
	end

	// round-robin sequencer
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			seq <= SEQ_BOUND;
			ch <= 2'h0;
			pcnt <= 32'h0;
			slow_cycle <= 1'b0;
			adc_start <= 1'b0;
			adc_chan <= 2'h0;
			cur_bus <= 16'h0;
			cur_sense <= 16'h0;
			cycle_done <= 1'b0;
			sleep <= 1'b0;
		end else begin
			cycle_done <= 1'b0;
			if (pcnt != 32'h0)
				pcnt <= pcnt - 32'h1;
			case (seq)
			SEQ_BOUND: begin
				pcnt <= rate_per - 32'h1;
				slow_cycle <= rate_per != 32'(PER_1024);
				ch <= 2'h0;
				sleep <= 1'b0;
				seq <= SEQ_START;
			end
			SEQ_START: begin
				if (act_ctrl.chan_en[ch]) begin
					adc_start <= 1'b1;
					adc_chan <= ch;
					seq <= SEQ_WAIT;
				end else if (last_ch) begin
					cycle_done <= 1'b1;
					seq <= SEQ_SLEEP;
				end else
					ch <= ch + 2'h1;
			end
			SEQ_WAIT: begin
				adc_start <= 1'b0;
				if (adc_done) begin
					// both converters sampled together; offset corrected
					cur_bus <= adc_bus - {{8{act_cfg.bus_off[7]}},
						act_cfg.bus_off};
					cur_sense <= adc_sense - {{8{act_cfg.sense_off[7]}},
						act_cfg.sense_off};
					seq <= SEQ_MATH;
				end
			end
			SEQ_MATH: begin
				if (last_ch) begin
					cycle_done <= 1'b1;
					seq <= SEQ_SLEEP;
				end else begin
					ch <= ch + 2'h1;
					seq <= SEQ_START;
				end
			end
			SEQ_SLEEP: begin
				sleep <= slow_cycle && pcnt > 32'h1;
				if (pcnt == 32'h0)
					seq <= SEQ_BOUND;
			end
			default: seq <= SEQ_BOUND;
			endcase
		end
	end

	// a clear zeroes count and sums together at a cycle end, so they agree
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n)
			clear_pend <= 1'b0;
		else if (snap_clear && !cycle_done)
			clear_pend <= 1'b1;
		else if (cycle_done)
			clear_pend <= 1'b0;
	end

	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n)
			live_count <= 32'h0;
		else if (zero_now)
			live_count <= 32'h0;
		else if (cycle_done)
			live_count <= live_count + 32'h1;
	end

	// the completed set counts the cycle that just ended
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n)
			comp_count <= 32'h0;
		else if (cycle_done)
			comp_count <= live_count + 32'h1;
	end

	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n)
			rd_count <= 32'h0;
		else if (snap)
			rd_count <= comp_count;
	end

	// per-channel live, completed and readable result sets
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic hit;
		assign hit = seq == SEQ_MATH && 32'(ch) == g;

		always_ff @(posedge pclk or negedge core_rst_n) begin
			if (!core_rst_n)
				live[g] <= '0;
			else begin
				if (hit) begin
					live[g].bus <= cur_bus;
					live[g].sense <= cur_sense;
					live[g].power <= pow;
				end
				if (zero_now)
					live[g].acc <= 32'h0;
				else if (hit)
					live[g].acc <= live[g].acc + {2'h0, pow};
			end
		end

		always_ff @(posedge pclk or negedge core_rst_n) begin
			if (!core_rst_n)
				comp[g] <= '0;
			else if (cycle_done)
				comp[g] <= live[g];
		end

		always_ff @(posedge pclk or negedge core_rst_n) begin
			if (!core_rst_n)
				rd[g] <= '0;
			else if (snap)
				rd[g] <= comp[g];
		end
	end

	// conversion-complete notice, held until the next snapshot
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n)
			notify_flag <= 1'b0;
		else if (cycle_done)
			notify_flag <= 1'b1;
		else if (snap)
			notify_flag <= 1'b0;
	end

	// multipurpose pins, open drain: drive low when enabled
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			rate_force_or_notify1_pin_oe <= 1'b0;
			general_io_or_notify2_pin_oe <= 1'b0;
		end else begin
			case (act_ctrl.pin1_mode)
			`PM_P1_NOTIFY: rate_force_or_notify1_pin_oe <= notify_flag;
			`PM_P1_GPOUT:
				rate_force_or_notify1_pin_oe <= ~act_ctrl.gpio_out[0];
			default: rate_force_or_notify1_pin_oe <= 1'b0;
			endcase
			case (act_ctrl.pin2_mode)
			`PM_P2_NOTIFY: general_io_or_notify2_pin_oe <= notify_flag;
			`PM_P2_GPOUT:
				general_io_or_notify2_pin_oe <= ~act_ctrl.gpio_out[1];
			default: general_io_or_notify2_pin_oe <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_force_or_notify1_pin_o <= 1'b0;
			general_io_or_notify2_pin_o <= 1'b0;
			powered_down <= 1'b0;
		end else begin
			rate_force_or_notify1_pin_o <= 1'b0;
			general_io_or_notify2_pin_o <= 1'b0;
			powered_down <= ~power_down_n;
		end
	end

	// apb slave: answer in the second access cycle
	logic [31:0] rdat;
	logic rerr;
	logic [11:0] roff;
	logic [1:0] rch;
	assign roff = paddr - `PM_A_RES;
	assign rch = roff[5:4];

	always_comb begin
		rdat = 32'h0;
		rerr = 1'b0;
		if (paddr == `PM_A_CMD)
			rerr = refuse;
		else if (paddr == `PM_A_CTRL) begin
			rdat = {19'h0, pend_ctrl};
			rerr = pwrite && refuse;
		end else if (paddr == `PM_A_CFG) begin
			rdat = {16'h0, pend_cfg};
			rerr = pwrite && refuse;
		end else if (paddr == `PM_A_STAT) begin
			rdat = {13'h0, notify_flag, general_io_or_notify2_pin_i,
				rate_force_or_notify1_pin_i, sleep, hold_busy,
				apply_pend, act_ctrl};
			rerr = pwrite;
		end else if (paddr == `PM_A_COUNT) begin
			rdat = rd_count;
			rerr = pwrite;
		end else if (paddr >= `PM_A_RES && roff < 12'(NCH * 16) &&
			!pwrite) begin
			case (roff[3:0])
			`PM_R_VOLT: rdat = {rd[rch].sense, rd[rch].bus};
			`PM_R_POW: rdat = {2'h0, rd[rch].power};
			`PM_R_ACC: rdat = rd[rch].acc;
			default: rerr = 1'b1;
			endcase
		end else
			rerr = 1'b1;
	end

	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= access;
			pslverr <= access & rerr;
			prdata <= (access && !pwrite) ? rdat : 32'h0;
		end
	end

endmodule

// file: test/pmsc_ctrl_properties.sv
`timescale 1ns/1ps
module pmsc_ctrl_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_down_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic adc_start,
	input wire logic [1:0] adc_chan,
	input wire logic sleep,
	input wire logic powered_down
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_ready_pulse;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready not one pulse after access");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready)
		else $error("pslverr without pready");
	property p_data_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_data_idle: assert property (p_data_idle)
		else $error("prdata not zero outside answer");
	property p_start_gap;
		adc_start |=> !adc_start [*2];
	endproperty
	a_start_gap: assert property (p_start_gap)
		else $error("conversion starts too close");
	property p_chan_moves;
		power_down_n && $changed(adc_chan) |-> adc_start;
	endproperty
	a_chan_moves: assert property (p_chan_moves)
		else $error("channel changed without start");
	property p_pd_follow;
		$past(presetn) |-> powered_down == !$past(power_down_n);
	endproperty
	a_pd_follow: assert property (p_pd_follow)
		else $error("powered_down does not follow input");
	property p_pd_quiet;
		!power_down_n |-> !adc_start && !sleep && !pready;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet)
		else $error("activity during power-down");
	property p_sleep_idle;
		sleep |-> !adc_start;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle)
		else $error("conversion started while asleep");
endmodule

bind pmsc_ctrl pmsc_ctrl_properties u_props (
	.pclk(pclk),
	.presetn(presetn),
	.power_down_n(power_down_n),
	.psel(psel),
	.penable(penable),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.adc_start(adc_start),
	.adc_chan(adc_chan),
	.sleep(sleep),
	.powered_down(powered_down)
);

// file: test/pmsc_adc_model.sv
`timescale 1ns/1ps
module pmsc_adc_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic adc_start,
	input wire logic [1:0] adc_chan,
	output logic adc_done,
	output logic [15:0] adc_bus,
	output logic [15:0] adc_sense
);
	logic [3:0] cnt;
	logic [15:0] junk;
	// odd channels answer fast, even ones slow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			adc_done <= 1'b0;
			junk <= 16'h5a5a;
		end else begin
			junk <= ~junk;
			adc_done <= cnt == 4'h1;
			if (adc_start)
				cnt <= adc_chan[0] ? 4'h2 : 4'h9;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
	// both results valid only in the done cycle
	assign adc_bus = adc_done ? 16'h0100 : junk;
	assign adc_sense = adc_done ? 16'h0040 : ~junk;
endmodule

// file: test/pmsc_ctrl_test.sv
`timescale 1ns/1ps
`include "pmsc_cfg.svh"
module pmsc_ctrl_test;
	logic pclk = 0, presetn = 0, power_down_n = 1, slow = 0;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, cnt;
	logic pready, pslverr, err, adc_start, adc_done, sleep, powered_down;
	logic [1:0] adc_chan;
	logic [15:0] adc_bus, adc_sense;
	logic p1_i, p1_oe, p2_i, p2_oe;
	logic [7:0] code;
	int num_errors = 0, n_checks = 0, n, i, j;
	always #5 pclk = ~pclk;
	// open-drain pins: pin one driven by bench from slow, pin two pulled up
	assign p1_i = slow & ~p1_oe;
	assign p2_i = ~p2_oe;

	pmsc_ctrl #(.PER_1024(64), .PER_256(128), .PER_64(256),
		.PER_8(512), .HOLD_CYC(50)) u_dut (
		.pclk(pclk), .presetn(presetn), .power_down_n(power_down_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_start(adc_start), .adc_chan(adc_chan),
		.adc_done(adc_done), .adc_bus(adc_bus), .adc_sense(adc_sense),
		.sleep(sleep), .powered_down(powered_down),
		.rate_force_or_notify1_pin_i(p1_i),
		.rate_force_or_notify1_pin_o(),
		.rate_force_or_notify1_pin_oe(p1_oe),
		.general_io_or_notify2_pin_i(p2_i),
		.general_io_or_notify2_pin_o(),
		.general_io_or_notify2_pin_oe(p2_oe));
	pmsc_adc_model u_adc (.pclk(pclk), .presetn(presetn),
		.adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
		.adc_bus(adc_bus), .adc_sense(adc_sense));

	task chk(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			num_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#400000;
		num_errors++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `PM_A_CTRL, 0);
		chk("ctrl", rd, {19'h0, `PM_CTRL_RST});
		chk("pin1 oe", {31'h0, p1_oe}, 0);
		chk("pin2 oe", {31'h0, p2_oe}, 0);
		$display("test reset done");
		apb(1, `PM_A_CTRL, 32'h00fc);
		repeat (200) @(posedge pclk);
		apb(0, `PM_A_STAT, 0);
		chk("stat pend", {19'h0, rd[12:0]}, {19'h0, `PM_CTRL_RST});
		apb(1, `PM_A_CMD, {24'h0, `PM_CMD_CLEAR});
		chk("cmd err", {31'h0, err}, 0);
		apb(1, `PM_A_CMD, {24'h0, `PM_CMD_KEEP});
		chk("hold err", {31'h0, err}, 1);
		repeat (300) @(posedge pclk);
		apb(0, `PM_A_STAT, 0);
		chk("stat act", {19'h0, rd[12:0]}, 32'h00fc);
		$display("test apply done");
		for (j = 0; j < 2; j++) begin
			code = j ? `PM_CMD_GLOBAL : `PM_CMD_CLEAR;
			repeat (600) @(posedge pclk);
			apb(1, `PM_A_CMD, {24'h0, `PM_CMD_KEEP});
			repeat (60) @(posedge pclk);
			for (i = 0; i < 4; i++) begin
				apb(0, 12'(`PM_A_RES + `PM_RES_STRIDE * i + `PM_R_VOLT), 0);
				chk("volt", rd, 32'h00400100);
				apb(0, 12'(`PM_A_RES + `PM_RES_STRIDE * i + `PM_R_POW), 0);
				chk("power", rd, 32'h00001000);
			end
			apb(0, `PM_A_COUNT, 0);
			cnt = rd;
			apb(0, 12'(`PM_A_RES + `PM_R_ACC), 0);
			chk("acc", rd, cnt * 32'h1000);
			chk("count live", {31'h0, cnt > 3}, 1);
			repeat (300) @(posedge pclk);
			apb(0, `PM_A_COUNT, 0);
			chk("count held", rd, cnt);
			apb(1, `PM_A_CMD, {24'h0, code});
			chk("clear err", {31'h0, err}, 0);
			repeat (150) @(posedge pclk);
			apb(1, `PM_A_CMD, {24'h0, `PM_CMD_KEEP});
			repeat (60) @(posedge pclk);
			apb(0, `PM_A_COUNT, 0);
			chk("count cleared", {31'h0, rd < 3}, 1);
		end
		apb(0, 12'hffc, 0);
		chk("unmapped", {31'h0, err}, 1);
		apb(1, `PM_A_COUNT, 32'h1);
		chk("ro write", {31'h0, err}, 1);
		$display("test snapshot done");
		for (j = 3; j >= 0; j--) begin
			apb(1, `PM_A_CTRL, 32'h00fc | j);
			repeat (60) @(posedge pclk);
			apb(1, `PM_A_CMD, {24'h0, `PM_CMD_KEEP});
			repeat (600) @(posedge pclk);
			n = 0;
			repeat (600) @(posedge pclk) n += sleep;
			chk("sleep", {31'h0, n > 0}, {31'h0, j != 0});
		end
		slow <= 1'b1;
		repeat (600) @(posedge pclk);
		n = 0;
		repeat (600) @(posedge pclk) n += sleep;
		chk("slow sleep", {31'h0, n > 0}, 1);
		slow <= 1'b0;
		$display("test rate done");
		power_down_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("powered down", {31'h0, powered_down}, 1);
		power_down_n <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(0, `PM_A_CTRL, 0);
		chk("ctrl after pd", rd, {19'h0, `PM_CTRL_RST});
		$display("test power-down done");
		test_done;
	end
endmodule
